// file: rtl/mfo_out_delay.sv
// per-output assert and release delay timer
`include "mfo_regs.svh"
`default_nettype none
module mfo_out_delay (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// timing
	input wire logic tick_i,
	input wire logic [9:0] assert_dly_i,
	input wire logic [9:0] release_dly_i,
	// condition and result
	input wire logic src_i,
	output logic closed_o
);

	mfo_pkg::mfo_dly_st_t st_q;
	mfo_pkg::mfo_dly_st_t st_d;
	logic [9:0] dly;

	always_comb begin
		st_d = st_q;
		dly = st_q.closed ? release_dly_i : assert_dly_i;
		// settings beyond 60.0 s saturate
		if (dly > `MFO_DLY_MAX) begin
			dly = `MFO_DLY_MAX;
		end
		if (src_i == st_q.closed) begin
			st_d.cnt = 10'h000;
		end else if (dly == 10'h000 ||
				(tick_i && st_q.cnt == dly - 10'h001)) begin
			st_d.closed = src_i;
			st_d.cnt = 10'h000;
		end else if (tick_i) begin
			st_d.cnt = st_q.cnt + 10'h001;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign closed_o = st_q.closed;

	// ************************************************************
	// checks
	// ************************************************************
	a_zero_delay: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(src_i != st_q.closed && dly == 10'h000) |=>
		closed_o == $past(src_i))
		else $error("zero delay did not follow at once");
	a_timer_restart: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(src_i == st_q.closed) |=>
		st_q.cnt == 10'h000 && $stable(closed_o))
		else $error("delay timer not restarted");
	a_no_early_flip: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(!tick_i && dly != 10'h000) |=> $stable(closed_o))
		else $error("output moved without a tick");

endmodule : mfo_out_delay
`default_nettype wire

// file: rtl/mfo_pkg.sv
// types of the multifunction output logic
`default_nettype none
package mfo_pkg;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic ready;
		logic fault_event;
		logic dir_cmd;
		logic base_lockout;
		logic drive_running;
		logic zero_speed;
		logic bus_ok;
		logic current_level;
		logic self_tuning;
		logic fault_forecast;
		logic alarm;
		logic heavy_load;
		logic generating;
		logic contactor_close;
		logic brake_release;
		logic pulse0;
		logic pulse1;
		logic radiator_hot;
		logic motor_hot;
		logic motor_second;
		logic encoder_second;
		logic brake_open;
		logic undervolt;
		logic ai_loss;
		logic reverse;
		logic sleeping;
	} mfo_drive_st_t;

	typedef struct packed {
		logic ext_reset;
		logic operator_reset;
		logic timed_reset;
	} mfo_clr_t;

	// all in 0.01 Hz
	typedef struct packed {
		logic [15:0] out_freq;
		logic [15:0] set_freq;
		logic [15:0] freq_match_width;
		logic [15:0] freq_detect_speed;
		logic [15:0] freq_detect_width;
	} mfo_freq_t;

	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} mfo_band_t;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic closed;
		logic [9:0] cnt;
	} mfo_dly_st_t;

	typedef struct packed {
		logic [1:0] din_m;
		logic [1:0] din_s;
		logic [5:0][7:0] fsel;
		logic [23:0] tick_cnt;
		logic tick;
		logic [15:0] acc_tcnt;
		logic [15:0] acc_hours;
		logic [15:0] run_tcnt;
		logic [15:0] run_hours;
		logic fdet1;
		logic fdet2;
		logic [2:0] band;
		logic freq_arrive_flag;
		logic fault;
		logic running;
		logic [4:0] therm_cnt;
		logic therm_fault;
		logic [9:0] fan_cnt;
		logic fan;
		logic [5:0] outs;
		logic [1:0] oc_oe;
	} mfo_st_t;

endpackage : mfo_pkg
`default_nettype wire

// file: rtl/mfo_regs.svh
// constants and timing counts of the multifunction output logic
`ifndef MFO_REGS_SVH
`define MFO_REGS_SVH

// ************************************************************
// timing
// ************************************************************
`define MFO_CLK_HZ 10_000_000
`define MFO_TICK_MS 100
`define MFO_TICK_CYC ((`MFO_CLK_HZ / 1000) * `MFO_TICK_MS)
`define MFO_FAN_HOLD_S 60
`define MFO_FAN_TICKS (`MFO_FAN_HOLD_S * 1000 / `MFO_TICK_MS)
`define MFO_THERM_S 2
`define MFO_THERM_TICKS (`MFO_THERM_S * 1000 / `MFO_TICK_MS)
`define MFO_HOUR_S 3600
`define MFO_HOUR_TICKS (`MFO_HOUR_S * 1000 / `MFO_TICK_MS)
`define MFO_DLY_MAX 10'h258

// ************************************************************
// function codes
// ************************************************************
`define MFO_INV_OFS 8'h64
`define MFO_CODE_MAX 8'h3f
`define MFO_FN_READY 1
`define MFO_FN_FAULT 2
`define MFO_FN_RUN 3
`define MFO_FN_FAR 4
`define MFO_FN_FDT 5
`define MFO_FN_ZERO_SPD 6
`define MFO_FN_BUS_OK 7
`define MFO_FN_CUR_LVL 8
`define MFO_FN_TUNE 9
`define MFO_FN_FDET1 10
`define MFO_FN_FDET2 11
`define MFO_FN_FORECAST 12
`define MFO_FN_ALARM 13
`define MFO_FN_ZS_TORQ 14
`define MFO_FN_ZERO_CUR 15
`define MFO_FN_REGEN 16
`define MFO_FN_CONTACTOR 17
`define MFO_FN_BRAKE_REL 18
`define MFO_FN_PULSE0 19
`define MFO_FN_PULSE1 20
`define MFO_FN_RAD_HOT 21
`define MFO_FN_MOT_HOT 22
`define MFO_FN_MOTOR_SEL 23
`define MFO_FN_ENC_SEL 24
`define MFO_FN_HOIST_BRK 25
`define MFO_FN_ACC_TIME 26
`define MFO_FN_RUN_TIME 27
`define MFO_FN_MIRROR1 28
`define MFO_FN_MIRROR2 29
`define MFO_FN_UNDERVOLT 30
`define MFO_FN_FAN 31
`define MFO_FN_AI_LOSS 32
`define MFO_FN_PTC 33
`define MFO_FN_REVERSE 34
`define MFO_FN_SLEEP 35
`define MFO_FN_BAND 51

`endif

// file: rtl/mfo_top.sv
// multifunction digital output logic of the drive
`include "mfo_regs.svh"
`default_nettype none
module mfo_top #(
	parameter int unsigned TICK_CYCLES = `MFO_TICK_CYC,
	parameter int unsigned HOUR_TICKS = `MFO_HOUR_TICKS,
	parameter int unsigned FAN_TICKS = `MFO_FAN_TICKS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// drive status and fault clearing
	input wire mfo_pkg::mfo_drive_st_t drive_i,
	input wire mfo_pkg::mfo_clr_t clr_i,
	// frequency settings and detector bands
	input wire mfo_pkg::mfo_freq_t freq_i,
	input wire mfo_pkg::mfo_band_t [2:0] band_i,
	// current, tenths of percent of rated
	input wire logic [15:0] current_pct_i,
	input wire logic [15:0] zero_current_threshold_i,
	// running time limits in hours
	input wire logic [15:0] single_runtime_limit_i,
	input wire logic [15:0] total_runtime_limit_i,
	// thermistor
	input wire logic [15:0] thermistor_level_i,
	input wire logic [15:0] thermistor_trip_level_i,
	// digital input pins
	input wire logic digital_in_one_i,
	input wire logic digital_in_two_i,
	// per-output configuration
	input wire logic [5:0][7:0] output_function_select_i,
	input wire logic [5:0][9:0] output_assert_delay_i,
	input wire logic [5:0][9:0] output_release_delay_i,
	// relay outputs, high means normally-open contact made
	output logic relay_out_a_o,
	output logic relay_out_b_o,
	output logic relay_out_c_o,
	output logic relay_out_d_o,
	// open-collector outputs
	output logic oc_out_a_o,
	output logic oc_out_a_oe_o,
	output logic oc_out_b_o,
	output logic oc_out_b_oe_o,
	// indications
	output logic running_o,
	output logic fault_o,
	output logic thermistor_fault_o,
	output logic freq_arrive_flag_o
);

	mfo_pkg::mfo_st_t st_q;
	mfo_pkg::mfo_st_t st_d;
	logic [63:0] cond;
	logic [5:0] raw;
	logic [5:0] closed_w;
	logic [16:0] spd_hi;
	logic [15:0] spd_lo;
	logic [15:0] far_diff;
	logic [15:0] fdt_diff;
	logic acc_done;
	logic run_done;
	logic zero_cur;
	logic fan_hot;
	logic therm_above;
	logic therm_trip;
	logic fault_clr;
	logic fault_set;

	// ************************************************************
	// combinational helpers
	// ************************************************************
	assign spd_hi = {1'b0, freq_i.freq_detect_speed} +
		{1'b0, freq_i.freq_detect_width};
	// saturates at zero so a wide band cannot wrap
	assign spd_lo = (freq_i.freq_detect_speed > freq_i.freq_detect_width) ?
		freq_i.freq_detect_speed - freq_i.freq_detect_width : 16'h0000;
	assign far_diff = (freq_i.out_freq > freq_i.set_freq) ?
		freq_i.out_freq - freq_i.set_freq :
		freq_i.set_freq - freq_i.out_freq;
	assign fdt_diff = (freq_i.out_freq > freq_i.freq_detect_speed) ?
		freq_i.out_freq - freq_i.freq_detect_speed :
		freq_i.freq_detect_speed - freq_i.out_freq;
	assign acc_done = st_q.acc_hours > total_runtime_limit_i;
	assign run_done = st_q.run_hours > single_runtime_limit_i;
	assign zero_cur = !drive_i.drive_running &&
		current_pct_i > zero_current_threshold_i;
	assign fan_hot = drive_i.drive_running || drive_i.radiator_hot ||
		drive_i.motor_hot;
	assign therm_above = thermistor_level_i > thermistor_trip_level_i;
	assign therm_trip = therm_above && st_q.tick &&
		st_q.therm_cnt == 5'(`MFO_THERM_TICKS - 1);
	assign fault_clr = clr_i.ext_reset || clr_i.operator_reset ||
		clr_i.timed_reset;
	assign fault_set = drive_i.fault_event || therm_trip;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		cond = 64'h0000_0000_0000_0000;
		st_d.din_m = {digital_in_two_i, digital_in_one_i};
		st_d.din_s = st_q.din_m;
		st_d.fsel = output_function_select_i;

		// tenth-of-a-second tick
		st_d.tick = 1'b0;
		if (st_q.tick_cnt == 24'(TICK_CYCLES - 1)) begin
			st_d.tick_cnt = 24'h00_0000;
			st_d.tick = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 24'h00_0001;
		end

		// running time, hours saturate
		if (st_q.tick && drive_i.drive_running) begin
			if (st_q.acc_tcnt == 16'(HOUR_TICKS - 1)) begin
				st_d.acc_tcnt = 16'h0000;
				if (st_q.acc_hours != 16'hffff) begin
					st_d.acc_hours = st_q.acc_hours + 16'h0001;
				end
			end else begin
				st_d.acc_tcnt = st_q.acc_tcnt + 16'h0001;
			end
			if (st_q.run_tcnt == 16'(HOUR_TICKS - 1)) begin
				st_d.run_tcnt = 16'h0000;
				if (st_q.run_hours != 16'hffff) begin
					st_d.run_hours = st_q.run_hours + 16'h0001;
				end
			end else begin
				st_d.run_tcnt = st_q.run_tcnt + 16'h0001;
			end
		end
		// a single run restarts from zero at each stop
		if (!drive_i.drive_running) begin
			st_d.run_tcnt = 16'h0000;
			st_d.run_hours = 16'h0000;
		end

		// frequency detectors with hysteresis
		if (!st_q.fdet1 && {1'b0, freq_i.out_freq} >= spd_hi) begin
			st_d.fdet1 = 1'b1;
		end else if (st_q.fdet1 &&
				freq_i.out_freq <= freq_i.freq_detect_speed) begin
			st_d.fdet1 = 1'b0;
		end
		if (!st_q.fdet2 && freq_i.out_freq >= freq_i.freq_detect_speed) begin
			st_d.fdet2 = 1'b1;
		end else if (st_q.fdet2 && freq_i.out_freq <= spd_lo) begin
			st_d.fdet2 = 1'b0;
		end
		for (int j = 0; j < 3; j++) begin
			if (freq_i.out_freq > band_i[j].upper) begin
				st_d.band[j] = 1'b1;
			end else if (freq_i.out_freq < band_i[j].lower) begin
				st_d.band[j] = 1'b0;
			end
		end
		st_d.freq_arrive_flag = far_diff <= freq_i.freq_match_width;

		// fault latch, a new fault beats a clear in the same cycle
		st_d.fault = fault_set || (st_q.fault && !fault_clr);
		st_d.running = drive_i.dir_cmd && !drive_i.base_lockout &&
			!st_d.fault;

		// thermistor qualifier
		if (!therm_above) begin
			st_d.therm_cnt = 5'h00;
		end else if (st_q.tick &&
				st_q.therm_cnt != 5'(`MFO_THERM_TICKS - 1)) begin
			st_d.therm_cnt = st_q.therm_cnt + 5'h01;
		end
		st_d.therm_fault = therm_trip ||
			(st_q.therm_fault && !fault_clr);

		// fan release delay
		if (fan_hot) begin
			st_d.fan = 1'b1;
			st_d.fan_cnt = 10'h000;
		end else if (st_q.fan && st_q.tick) begin
			if (st_q.fan_cnt == 10'(FAN_TICKS - 1)) begin
				st_d.fan = 1'b0;
				st_d.fan_cnt = 10'h000;
			end else begin
				st_d.fan_cnt = st_q.fan_cnt + 10'h001;
			end
		end

		// condition per base code, 1 means closed
		cond[`MFO_FN_READY] = drive_i.ready;
		cond[`MFO_FN_FAULT] = st_q.fault;
		cond[`MFO_FN_RUN] = st_q.running;
		cond[`MFO_FN_FAR] = st_q.freq_arrive_flag;
		cond[`MFO_FN_FDT] = fdt_diff <= freq_i.freq_detect_width;
		cond[`MFO_FN_ZERO_SPD] = drive_i.zero_speed;
		cond[`MFO_FN_BUS_OK] = drive_i.bus_ok;
		cond[`MFO_FN_CUR_LVL] = drive_i.current_level;
		cond[`MFO_FN_TUNE] = drive_i.self_tuning;
		cond[`MFO_FN_FDET1] = !st_q.fdet1;
		cond[`MFO_FN_FDET2] = st_q.fdet2;
		cond[`MFO_FN_FORECAST] = drive_i.fault_forecast;
		cond[`MFO_FN_ALARM] = drive_i.alarm && !st_q.fault;
		cond[`MFO_FN_ZS_TORQ] = drive_i.heavy_load;
		cond[`MFO_FN_ZERO_CUR] = zero_cur;
		cond[`MFO_FN_REGEN] = drive_i.generating;
		cond[`MFO_FN_CONTACTOR] = drive_i.contactor_close;
		cond[`MFO_FN_BRAKE_REL] = drive_i.brake_release;
		cond[`MFO_FN_PULSE0] = drive_i.pulse0;
		cond[`MFO_FN_PULSE1] = drive_i.pulse1;
		cond[`MFO_FN_RAD_HOT] = drive_i.radiator_hot;
		cond[`MFO_FN_MOT_HOT] = drive_i.motor_hot;
		cond[`MFO_FN_MOTOR_SEL] = drive_i.motor_second;
		cond[`MFO_FN_ENC_SEL] = drive_i.encoder_second;
		cond[`MFO_FN_HOIST_BRK] = drive_i.brake_open;
		cond[`MFO_FN_ACC_TIME] = acc_done;
		cond[`MFO_FN_RUN_TIME] = run_done;
		cond[`MFO_FN_MIRROR1] = st_q.din_s[0];
		cond[`MFO_FN_MIRROR2] = st_q.din_s[1];
		cond[`MFO_FN_UNDERVOLT] = drive_i.undervolt;
		cond[`MFO_FN_FAN] = st_q.fan;
		cond[`MFO_FN_AI_LOSS] = drive_i.ai_loss;
		cond[`MFO_FN_PTC] = st_q.therm_fault;
		cond[`MFO_FN_REVERSE] = drive_i.reverse;
		cond[`MFO_FN_SLEEP] = drive_i.sleeping;
		cond[`MFO_FN_BAND +: 3] = st_q.band;

		// output stage, collector enable low while pulling low
		st_d.outs = closed_w;
		st_d.oc_oe = ~closed_w[5:4];
	end

	// ************************************************************
	// per-output selection and delay
	// ************************************************************
	generate
		for (genvar i = 0; i < 6; i++) begin : g_out
			logic inv;
			logic [7:0] base;
			logic valid;
			assign inv = st_q.fsel[i] >= `MFO_INV_OFS;
			assign base = inv ? st_q.fsel[i] - `MFO_INV_OFS : st_q.fsel[i];
			// no-function and out-of-range codes stay open either way
			assign valid = base != 8'h00 && base <= `MFO_CODE_MAX;
			assign raw[i] = valid && (cond[base[5:0]] ^ inv);
			mfo_out_delay u_dly (
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.tick_i(st_q.tick),
				.assert_dly_i(output_assert_delay_i[i]),
				.release_dly_i(output_release_delay_i[i]),
				.src_i(raw[i]),
				.closed_o(closed_w[i])
			);
		end
	endgenerate

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
			st_q.oc_oe <= 2'h3;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign relay_out_a_o = st_q.outs[0];
	assign relay_out_b_o = st_q.outs[1];
	assign relay_out_c_o = st_q.outs[2];
	assign relay_out_d_o = st_q.outs[3];
	// collector only ever sinks, so its level is fixed low
	assign oc_out_a_o = 1'b0;
	assign oc_out_b_o = 1'b0;
	assign oc_out_a_oe_o = st_q.oc_oe[0];
	assign oc_out_b_oe_o = st_q.oc_oe[1];
	assign running_o = st_q.running;
	assign fault_o = st_q.fault;
	assign thermistor_fault_o = st_q.therm_fault;
	assign freq_arrive_flag_o = st_q.freq_arrive_flag;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_fault_latch: assert property (drive_i.fault_event |=> fault_o)
		else $error("fault event not latched");
	a_fault_hold: assert property (fault_o && !fault_clr |=> fault_o)
		else $error("fault dropped without a clear");
	a_run_clear: assert property (drive_i.fault_event |=> !running_o)
		else $error("running not cleared by fault");
	a_run_cause: assert property (running_o |->
		$past(drive_i.dir_cmd) && !$past(drive_i.base_lockout))
		else $error("running without direction");
	a_fdet1_trig: assert property (!st_q.fdet1 &&
		{1'b0, freq_i.out_freq} >= spd_hi |=> st_q.fdet1)
		else $error("detector one missed trigger");
	a_fdet1_hold: assert property (st_q.fdet1 &&
		freq_i.out_freq > freq_i.freq_detect_speed |=> st_q.fdet1)
		else $error("detector one reset early");
	a_fdet2_hold: assert property (st_q.fdet2 &&
		freq_i.out_freq > spd_lo |=> st_q.fdet2)
		else $error("detector two reset early");
	a_band_set: assert property (freq_i.out_freq > band_i[0].upper
		|=> st_q.band[0])
		else $error("band detector missed upper limit");
	a_far_flag: assert property (far_diff <= freq_i.freq_match_width
		|=> freq_arrive_flag_o)
		else $error("frequency arrive not shown");
	a_fan_on: assert property (fan_hot |=> st_q.fan ##1 st_q.fan)
		else $error("fan not held on");
	a_therm_time: assert property ($rose(thermistor_fault_o) |->
		$past(st_q.therm_cnt) == 5'(`MFO_THERM_TICKS - 1))
		else $error("thermistor fault before two seconds");
	a_oc_pair: assert property (oc_out_a_oe_o == !$past(closed_w[4]))
		else $error("collector enable not inverse of state");

	c_fault_seen: cover property (drive_i.fault_event ##1 fault_o);
	c_fdet1_cycle: cover property ($rose(st_q.fdet1) ##[1:50] $fell(st_q.fdet1));
	c_fan_release: cover property ($fell(st_q.fan));
	c_therm_trip: cover property ($rose(thermistor_fault_o));

endmodule : mfo_top
`default_nettype wire

// file: tb/mfo_loads.sv
// relays, contactors and lamps wired to the output points
`default_nettype none
module mfo_loads (
	// from the output points
	input wire logic [3:0] relay_i,
	input wire logic [1:0] oc_i,
	input wire logic [1:0] oc_oe_i,
	// as seen by the loads
	output logic [3:0] nc_made_o,
	output logic [1:0] line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	assign nc_made_o = ~relay_i;
	// load supply pulls a released collector high
	assign line_o[0] = oc_oe_i[0] ? 1'b1 : oc_i[0];
	assign line_o[1] = oc_oe_i[1] ? 1'b1 : oc_i[1];
endmodule : mfo_loads
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the multifunction output logic
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	mfo_pkg::mfo_drive_st_t drv = '0;
	mfo_pkg::mfo_clr_t clr = '0;
	mfo_pkg::mfo_freq_t frq = '0;
	mfo_pkg::mfo_band_t [2:0] band = '0;
	logic [15:0] cur = '0;
	logic [15:0] zthr = '0;
	logic [15:0] slim = '0;
	logic [15:0] tlim = '0;
	logic [15:0] thl = '0;
	logic [15:0] thtrip = '0;
	logic din1 = 1'b0;
	logic din2 = 1'b0;
	logic [5:0][7:0] fsel = '0;
	logic [5:0][9:0] adly = '0;
	logic [5:0][9:0] rdly = '0;
	logic [3:0] ro;
	logic [1:0] oc;
	logic [1:0] oe;
	logic [3:0] nc;
	logic [1:0] line;
	logic run;
	logic flt;
	logic thf;
	logic freq_arrive_flag;
	int n_errors = 0;
	int total_checks = 0;
	int codes[31] = '{0, 1, 2, 3, 6, 7, 8, 9, 12, 13, 14, 15, 16, 17, 18, 19,
		20, 21, 22, 23, 24, 25, 28, 29, 30, 32, 33, 34, 35, 40, 63};
	int fl[14] = '{0, 1000, 1100, 1199, 1200, 1100, 1001, 1000, 900, 801,
		800, 1600, 1500, 400};
	int f;
	logic t1 = 1'b0;
	logic t2 = 1'b0;
	logic bd = 1'b0;

	always #50 clk = ~clk;

	mfo_top #(.TICK_CYCLES(10), .HOUR_TICKS(4), .FAN_TICKS(5)) dut (
		.clk_i(clk), .nrst_i(nrst), .drive_i(drv), .clr_i(clr),
		.freq_i(frq), .band_i(band), .current_pct_i(cur),
		.zero_current_threshold_i(zthr),
		.single_runtime_limit_i(slim), .total_runtime_limit_i(tlim),
		.thermistor_level_i(thl), .thermistor_trip_level_i(thtrip),
		.digital_in_one_i(din1), .digital_in_two_i(din2),
		.output_function_select_i(fsel), .output_assert_delay_i(adly),
		.output_release_delay_i(rdly), .relay_out_a_o(ro[0]),
		.relay_out_b_o(ro[1]), .relay_out_c_o(ro[2]),
		.relay_out_d_o(ro[3]), .oc_out_a_o(oc[0]), .oc_out_a_oe_o(oe[0]),
		.oc_out_b_o(oc[1]), .oc_out_b_oe_o(oe[1]), .running_o(run),
		.fault_o(flt), .thermistor_fault_o(thf), .freq_arrive_flag_o(freq_arrive_flag)
	);

	mfo_loads loads (
		.relay_i(ro), .oc_i(oc), .oc_oe_i(oe), .nc_made_o(nc),
		.line_o(line)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : cyc

	task automatic chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask : chk

	function automatic logic closed(input int i);
		return (i < 4) ? ro[i] : ~line[i - 4];
	endfunction : closed

	// expected point state for a direct or inverted code, no fault latched
	function automatic logic mdl(input int c);
		int b;
		logic v;
		b = c % 100;
		case (b)
			1: v = drv.ready;
			3: v = drv.dir_cmd && !drv.base_lockout;
			6: v = drv.zero_speed;
			7: v = drv.bus_ok;
			8: v = drv.current_level;
			14: v = drv.heavy_load;
			18: v = drv.brake_release;
			19: v = drv.pulse0;
			20: v = drv.pulse1;
			21: v = drv.radiator_hot;
			22: v = drv.motor_hot;
			30: v = drv.undervolt;
			32: v = drv.ai_loss;
			34: v = drv.reverse;
			35: v = drv.sleeping;
			9: v = drv.self_tuning;
			12: v = drv.fault_forecast;
			13: v = drv.alarm;
			15: v = (cur > zthr) && !drv.drive_running;
			16: v = drv.generating;
			17: v = drv.contactor_close;
			23: v = drv.motor_second;
			24: v = drv.encoder_second;
			25: v = drv.brake_open;
			28: v = din1;
			29: v = din2;
			default: v = 1'b0;
		endcase
		return (b == 0) ? 1'b0 : v ^ (c >= 100);
	endfunction : mdl

	task automatic conclude;
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		void'($urandom(32'hb33d_340f));
		cyc(2);
		for (int i = 0; i < 6; i++) chk(closed(i), 1'b0);
		chk(run | flt | thf | freq_arrive_flag, 1'b0);
		cyc(1);
		nrst = 1'b1;
		zthr = 16'h01f4;
		foreach (codes[k]) for (int v = 0; v < 2; v++) begin
			fsel[0] = 8'(codes[k] + 100 * v);
			drv = mfo_pkg::mfo_drive_st_t'($urandom);
			drv.fault_event = 1'b0;
			cur = 16'($urandom_range(0, 999));
			din1 = 1'($urandom);
			din2 = 1'($urandom);
			cyc(8);
			chk(closed(0), mdl(fsel[0]));
			chk(nc[0], ~mdl(fsel[0]));
		end
		drv = '0;
		frq = {16'h0000, 16'h04b0, 16'h0064, 16'h03e8, 16'h00c8};
		band = {3{32'h05dc_01f4}};
		fsel[1] = 8'h0a;
		fsel[2] = 8'h6f;
		fsel[3] = 8'h33;
		for (int k = 0; k < 24; k++) begin
			f = (k < 14) ? fl[k] : $urandom_range(0, 2000);
			frq.out_freq = 16'(f);
			t1 = (f >= 1200) ? 1'b1 : (f <= 1000) ? 1'b0 : t1;
			t2 = (f >= 1000) ? 1'b1 : (f <= 800) ? 1'b0 : t2;
			bd = (f > 1500) ? 1'b1 : (f < 500) ? 1'b0 : bd;
			cyc(8);
			chk(ro[1], ~t1);
			chk(ro[2], ~t2);
			chk(ro[3], bd);
			chk(freq_arrive_flag, (f >= 1100) && (f <= 1300));
		end
		fsel[1] = 8'h0d;
		drv.alarm = 1'b1;
		drv.dir_cmd = 1'b1;
		cyc(6);
		chk(run, 1'b1);
		drv.base_lockout = 1'b1;
		cyc(4);
		chk(run, 1'b0);
		drv.base_lockout = 1'b0;
		cyc(4);
		for (int k = 0; k < 3; k++) begin
			drv.fault_event = 1'b1;
			cyc(1);
			drv.fault_event = 1'b0;
			cyc(4);
			chk(flt & ~run, 1'b1);
			chk(ro[1], 1'b0);
			clr = mfo_pkg::mfo_clr_t'(3'h1 << k);
			cyc(1);
			clr = '0;
			cyc(4);
			chk(~flt & run & ro[1], 1'b1);
		end
		fsel[4] = 8'h09;
		adly[4] = 10'h003;
		rdly[4] = 10'h002;
		cyc(20);
		drv.self_tuning = 1'b1;
		cyc(12);
		chk(closed(4), 1'b0);
		cyc(30);
		chk(closed(4), 1'b1);
		drv.self_tuning = 1'b0;
		cyc(8);
		drv.self_tuning = 1'b1;
		cyc(40);
		chk(closed(4), 1'b1);
		drv.self_tuning = 1'b0;
		cyc(6);
		chk(closed(4), 1'b1);
		cyc(30);
		chk(closed(4), 1'b0);
		thtrip = 16'h0064;
		thl = 16'h00c8;
		cyc(150);
		thl = 16'h0000;
		cyc(3);
		thl = 16'h00c8;
		cyc(150);
		chk(thf, 1'b0);
		cyc(80);
		chk(thf & flt, 1'b1);
		thl = 16'h0000;
		clr.timed_reset = 1'b1;
		cyc(1);
		clr = '0;
		cyc(4);
		chk(thf | flt, 1'b0);
		fsel[5] = 8'h1f;
		drv.drive_running = 1'b1;
		cyc(6);
		chk(closed(5), 1'b1);
		drv.drive_running = 1'b0;
		cyc(30);
		chk(closed(5), 1'b1);
		cyc(40);
		chk(closed(5), 1'b0);
		drv.radiator_hot = 1'b1;
		cyc(6);
		chk(closed(5), 1'b1);
		drv.radiator_hot = 1'b0;
		fsel[5] = 8'h1b;
		slim = 16'h0001;
		drv.drive_running = 1'b1;
		cyc(30);
		chk(closed(5), 1'b0);
		cyc(100);
		chk(closed(5), 1'b1);
		drv.drive_running = 1'b0;
		cyc(6);
		chk(closed(5), 1'b0);
		conclude();
	end
endmodule : testbench
`default_nettype wire
